// ### rtl/ulf_pkg.sv
// Package with register map, field positions, reset values and types for the serial port core
// Notes on behaviour
// - A character is start, 5-8 data, optional parity, then 1, 1.5 or 2 stops.
// - Divisor 1..65535 divides the clock into a 16x bit-rate tick for transmit.
// - The receiver runs from the same 16x tick, sharing one programmed rate.
// - Separate 16-entry receive and transmit byte FIFOs reduce processor interrupts.
// - The divisor can be set to a value giving the MIDI data rate.
// - Divisor access bit 7 set maps offsets 0 and 1 to divisor low and high.
// - Access bit clear: offset 0 reads receive, writes transmit; offset 1 is enables.
// - Bit 6 holds the serial output low while the transmitter keeps running.
// - Fixed parity with sense 1 sends and checks 0; sense 0 gives 1.
// - Parity from count of ones; sense bit 4 set is even, clear is odd.
// - Bit 3 inserts a parity bit after the data; the receiver checks it.
// - Bit 2 gives 1 stop, or 1.5 for five bits and 2 otherwise.
// - Length bits 1:0 select five, six, seven or eight data bits.
// - Interrupt enable bits 0..3 are rx ready, tx empty, line, modem; 7:4 zero.
// - Data bit 0, the least significant, goes first on the line.
// - Overrun, parity, stop and silent-line flags clear when line status is read.
// - Data ready is 1 while received data remain and 0 once none remain.
package ulf_pkg;
	localparam logic [11:0] OFS_DATA = 12'h000;
	localparam logic [11:0] OFS_IEN = 12'h004;
	localparam logic [11:0] OFS_IID = 12'h008;
	localparam logic [11:0] OFS_LFC = 12'h00C;
	localparam logic [11:0] OFS_LSR = 12'h014;
	localparam logic [11:0] OFS_MSR = 12'h018;
	localparam logic [11:0] OFS_IST = 12'h020;
	localparam logic [11:0] OFS_IMSK = 12'h024;
	localparam logic [7:0] LFC_RESET = 8'h00;
	localparam logic [15:0] DIV_RESET = 16'h0001;
	localparam logic [3:0] IEN_RESET = 4'h0;
	localparam logic [3:0] TICKS_PER_BIT = 4'hF;
	localparam logic [3:0] TICKS_HALF = 4'h7;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_AW = 4;
	localparam int IST_RX = 0;
	localparam int IST_TXE = 1;
	localparam int IST_LINE = 2;
	// Line format control layout
	typedef struct packed {
		logic divisor_latch_access;
		logic force_line_low;
		logic fixed_parity_enable;
		logic parity_sense_select;
		logic parity_insert_enable;
		logic extra_stop_enable;
		logic char_length_sel_hi;
		logic char_length_sel_lo;
	} ulf_lfc_s;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b010,
		ST_PAR = 3'b011,
		ST_STOP = 3'b100
	} ulf_state_e;
endpackage : ulf_pkg

// ### rtl/ulf_uart.sv
// Serial port core: APB registers, baud generator, transmitter, receiver and FIFOs
`timescale 1ns/1ps
module ulf_uart
	import ulf_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_in,
	output logic serial_out,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	// Registers
	ulf_lfc_s lfc_q;
	logic [15:0] div_q;
	logic [3:0] ien_q;
	logic [2:0] ist_q;
	logic [2:0] imsk_q;
	logic fifo_en_q;
	logic ovr_q, per_q, fer_q, sil_q;
	logic [DEPTH-1:0][7:0] rxm_q;
	logic [DEPTH-1:0][7:0] txm_q;
	logic [FIFO_AW:0] rxc_q, txc_q;
	logic [FIFO_AW-1:0] rxr_q, rxw_q, txr_q, txw_q;
	logic wr, rd, acc;
	logic rx_push, tx_pop, rx_pop, tx_push, rx_full, tx_full;
	logic [7:0] rx_byte;
	logic rx_perr, rx_ferr, rx_sil;
	logic tx_idle;
	logic [FIFO_AW:0] rx_cap, tx_cap;

	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	// Non-FIFO mode behaves as one-entry holding registers
	assign rx_cap = fifo_en_q ? (FIFO_AW+1)'(DEPTH) : (FIFO_AW+1)'(1);
	assign tx_cap = rx_cap;
	assign rx_full = rxc_q >= rx_cap;
	assign tx_full = txc_q >= tx_cap;
	assign rx_pop = clk_en && rd && paddr == OFS_DATA && !lfc_q.divisor_latch_access && rxc_q != '0;
	assign tx_push = clk_en && wr && paddr == OFS_DATA && !lfc_q.divisor_latch_access && !tx_full;

	////////////////////////////////////////////////////////////////////////
	// Control registers written by software
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lfc_q <= LFC_RESET;
			div_q <= DIV_RESET;
			ien_q <= IEN_RESET;
			imsk_q <= '0;
			fifo_en_q <= 1'b0;
		end
		else if (clk_en && wr)
		begin
			case (paddr)
				OFS_DATA: if (lfc_q.divisor_latch_access) div_q[7:0] <= pwdata[7:0];
				OFS_IEN:
				begin
					if (lfc_q.divisor_latch_access)
						div_q[15:8] <= pwdata[7:0];
					else
						ien_q <= pwdata[3:0];
				end
				OFS_IID: fifo_en_q <= pwdata[0];
				OFS_LFC: lfc_q <= pwdata[7:0];
				OFS_IMSK: imsk_q <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux and APB answer; zero wait states, unmapped gives pslverr
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= '0;
			if (psel && !penable && !pwrite)
			begin
				case (paddr)
					OFS_DATA: prdata[7:0] <= lfc_q.divisor_latch_access ? div_q[7:0] : rxm_q[rxr_q];
					OFS_IEN: prdata[7:0] <= lfc_q.divisor_latch_access ? div_q[15:8] : {4'h0, ien_q};
					OFS_IID: prdata[7:0] <= iid_value();
					OFS_LFC: prdata[7:0] <= lfc_q;
					OFS_LSR: prdata[7:0] <= {1'b0, txc_q == '0 && tx_idle, txc_q == '0, sil_q, fer_q, per_q, ovr_q,
						rxc_q != '0};
					OFS_MSR: prdata[7:0] <= 8'h00;
					OFS_IST: prdata[2:0] <= ist_q;
					OFS_IMSK: prdata[2:0] <= imsk_q;
					default: pslverr <= 1'b0;
				endcase
			end
			if (psel && !penable && !(paddr inside {OFS_DATA, OFS_IEN, OFS_IID, OFS_LFC, OFS_LSR, OFS_MSR, OFS_IST,
				OFS_IMSK}))
				pslverr <= 1'b1;
		end
	end

	// Identification: bit 0 low when pending, priority line > rx > tx empty
	function automatic logic [7:0] iid_value();
		logic [7:0] v;
		v = {fifo_en_q, fifo_en_q, 6'h01};
		if (ien_q[2] && (ovr_q || per_q || fer_q || sil_q))
			v[3:0] = 4'h6;
		else if (ien_q[0] && rxc_q != '0)
			v[3:0] = 4'h4;
		else if (ien_q[1] && txc_q == '0)
			v[3:0] = 4'h2;
		return v;
	endfunction : iid_value

	////////////////////////////////////////////////////////////////////////
	// Line status flags; a new event wins over the read clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ovr_q <= 1'b0;
			per_q <= 1'b0;
			fer_q <= 1'b0;
			sil_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (rd && paddr == OFS_LSR)
			begin
				ovr_q <= 1'b0;
				per_q <= 1'b0;
				fer_q <= 1'b0;
				sil_q <= 1'b0;
			end
			if (rx_push)
			begin
				if (rx_full && !rx_pop) ovr_q <= 1'b1;
				if (rx_perr) per_q <= 1'b1;
				if (rx_ferr) fer_q <= 1'b1;
				if (rx_sil) sil_q <= 1'b1;
			end
		end
	end

	// Sticky interrupt status, cleared by reading it; set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ist_q <= '0;
		else if (clk_en)
			ist_q <= (rd && paddr == OFS_IST ? 3'b000 : ist_q)
				| {rx_push && (rx_perr || rx_ferr || rx_sil || rx_full), tx_pop && ien_q[1], rx_push && ien_q[0]};
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else if (clk_en)
			irq <= |(ist_q & imsk_q);
	end

	////////////////////////////////////////////////////////////////////////
	// FIFOs; overflowing receive byte is dropped and flagged as overrun
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rxr_q <= '0;
			rxw_q <= '0;
			rxc_q <= '0;
			txr_q <= '0;
			txw_q <= '0;
			txc_q <= '0;
		end
		else if (clk_en)
		begin
			if (wr && paddr == OFS_IID && pwdata[1])
			begin
				rxr_q <= '0;
				rxw_q <= '0;
				rxc_q <= '0;
			end
			else
			begin
				if (rx_push && (!rx_full || rx_pop)) rxw_q <= rxw_q + 1'b1;
				if (rx_pop) rxr_q <= rxr_q + 1'b1;
				rxc_q <= rxc_q + (FIFO_AW+1)'(rx_push && (!rx_full || rx_pop)) - (FIFO_AW+1)'(rx_pop);
			end
			if (wr && paddr == OFS_IID && pwdata[2])
			begin
				txr_q <= '0;
				txw_q <= '0;
				txc_q <= '0;
			end
			else
			begin
				if (tx_push) txw_q <= txw_q + 1'b1;
				if (tx_pop) txr_q <= txr_q + 1'b1;
				txc_q <= txc_q + (FIFO_AW+1)'(tx_push) - (FIFO_AW+1)'(tx_pop);
			end
		end
	end

	always_ff @(posedge pclk)
	begin
		if (clk_en && rx_push && (!rx_full || rx_pop)) rxm_q[rxw_q] <= rx_byte;
		if (clk_en && tx_push) txm_q[txw_q] <= pwdata[7:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Baud generator: one 16x tick every div_q clocks; zero treated as one
	logic [15:0] bcnt_q;
	logic tick;
	assign tick = bcnt_q <= 16'h0001;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bcnt_q <= 16'h0001;
		else if (clk_en && wr && lfc_q.divisor_latch_access && paddr inside {OFS_DATA, OFS_IEN})
			bcnt_q <= 16'h0001; // Divisor write restarts the count, else a large old divisor stalls the new rate
		else if (clk_en)
			bcnt_q <= tick ? div_q : bcnt_q - 16'h0001;
	end
	// Character shape shared by both directions
	logic [2:0] nbits;
	assign nbits = 3'(4 + {lfc_q.char_length_sel_hi, lfc_q.char_length_sel_lo}); // last index
	function automatic logic par_bit(input logic [7:0] d);
		logic [7:0] m;
		m = d & (8'hFF >> (3'h7 - nbits));
		if (lfc_q.fixed_parity_enable) return !lfc_q.parity_sense_select;
		return lfc_q.parity_sense_select ? ^m : !(^m);
	endfunction : par_bit

	////////////////////////////////////////////////////////////////////////
	// Transmitter
	ulf_state_e ts_q;
	logic [7:0] tsh_q;
	logic [2:0] tbit_q;
	logic [4:0] tsub_q;
	logic tline_q;
	logic [4:0] tstop_len;
	assign tx_idle = ts_q == ST_IDLE;
	assign tx_pop = clk_en && tick && tx_idle && txc_q != '0;
	// 1 stop bit; with extra stop, 1.5 for five bits, else 2
	assign tstop_len = !lfc_q.extra_stop_enable ? 5'd15 : (nbits == 3'd4 ? 5'd23 : 5'd31);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ts_q <= ST_IDLE;
			tsh_q <= '0;
			tbit_q <= '0;
			tsub_q <= '0;
			tline_q <= 1'b1;
		end
		else if (clk_en && tick)
		begin
			tsub_q <= tsub_q + 5'd1;
			case (ts_q)
				ST_IDLE:
				begin
					tline_q <= 1'b1;
					if (txc_q != '0)
					begin
						tsh_q <= txm_q[txr_q];
						ts_q <= ST_START;
						tline_q <= 1'b0;
						tsub_q <= '0;
					end
				end
				ST_START: if (tsub_q == 5'd15)
				begin
					ts_q <= ST_DATA;
					tline_q <= tsh_q[0];
					tbit_q <= '0;
					tsub_q <= '0;
				end
				ST_DATA: if (tsub_q == 5'd15)
				begin
					tsub_q <= '0;
					tbit_q <= tbit_q + 3'd1;
					tline_q <= tsh_q[tbit_q + 3'd1];
					if (tbit_q == nbits)
					begin
						ts_q <= lfc_q.parity_insert_enable ? ST_PAR : ST_STOP;
						tline_q <= lfc_q.parity_insert_enable ? par_bit(tsh_q) : 1'b1;
					end
				end
				ST_PAR: if (tsub_q == 5'd15)
				begin
					ts_q <= ST_STOP;
					tline_q <= 1'b1;
					tsub_q <= '0;
				end
				ST_STOP: if (tsub_q == tstop_len) ts_q <= ST_IDLE;
				default: ts_q <= ST_IDLE;
			endcase
		end
	end

	// Forced low only gates the pin; the shifter runs on
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			serial_out <= 1'b1;
		else if (clk_en)
			serial_out <= tline_q && !lfc_q.force_line_low;
	end

	////////////////////////////////////////////////////////////////////////
	// Receiver on the same 16x tick
	ulf_state_e rs_q;
	logic [3:0] rsub_q;
	logic [2:0] rbit_q;
	logic [7:0] rsh_q;
	logic rin_q, rpe_q, rall0_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rs_q <= ST_IDLE;
			rsub_q <= '0;
			rbit_q <= '0;
			rsh_q <= '0;
			rin_q <= 1'b1;
			rpe_q <= 1'b0;
			rall0_q <= 1'b0;
			rx_push <= 1'b0;
			rx_byte <= '0;
			rx_perr <= 1'b0;
			rx_ferr <= 1'b0;
			rx_sil <= 1'b0;
		end
		else if (clk_en)
		begin
			rx_push <= 1'b0;
			if (tick)
			begin
				rin_q <= serial_in;
				rsub_q <= rsub_q + 4'h1;
				case (rs_q)
					ST_IDLE: if (rin_q && !serial_in)
					begin
						rs_q <= ST_START; // falling edge
						rsub_q <= '0;
					end
					ST_START: if (rsub_q == TICKS_HALF)
					begin
						rsub_q <= '0;
						rbit_q <= '0;
						rsh_q <= '0;
						rpe_q <= 1'b0;
						rall0_q <= 1'b1;
						rs_q <= serial_in ? ST_IDLE : ST_DATA; // confirm
					end
					ST_DATA: if (rsub_q == TICKS_PER_BIT)
					begin
						rsh_q[rbit_q] <= serial_in;
						rall0_q <= rall0_q && !serial_in;
						rbit_q <= rbit_q + 3'd1;
						if (rbit_q == nbits) rs_q <= lfc_q.parity_insert_enable ? ST_PAR : ST_STOP;
					end
					ST_PAR: if (rsub_q == TICKS_PER_BIT)
					begin
						rpe_q <= serial_in != par_bit(rsh_q);
						rall0_q <= rall0_q && !serial_in;
						rs_q <= ST_STOP;
					end
					ST_STOP: if (rsub_q == TICKS_PER_BIT)
					begin
						rx_push <= 1'b1; // Only the first stop bit is checked
						rx_byte <= rsh_q;
						rx_perr <= rpe_q;
						rx_ferr <= !serial_in;
						rx_sil <= rall0_q && !serial_in;
						rs_q <= ST_IDLE;
					end
					default: rs_q <= ST_IDLE;
				endcase
			end
		end
	end
endmodule : ulf_uart

// ### testbench/ulf_uart_monitor.sv
// Checker for the serial port core, bound to its ports
`timescale 1ns/1ps
module ulf_uart_monitor
	import ulf_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic irq
);
	logic [7:0] lfc_q;
	logic [7:0] dhi_q;
	logic [3:0] ien_q;
	logic [2:0] msk_q;
	logic wr;
	logic rd;
	logic map;
	// Completed transfers and address decode
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;
	assign map = paddr inside {OFS_DATA, OFS_IEN, OFS_IID, OFS_LFC, OFS_LSR, OFS_MSR, OFS_IST, OFS_IMSK};
	////////////////////////////////////////////////////////////////////////////////
	// Shadow registers, updated on the same edge the core takes a write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lfc_q <= LFC_RESET;
			dhi_q <= DIV_RESET[15:8];
			ien_q <= IEN_RESET;
			msk_q <= 3'h0;
		end
		else if (wr)
		begin
			if (paddr == OFS_LFC)
				lfc_q <= pwdata[7:0];
			if (paddr == OFS_IEN && lfc_q[7])
				dhi_q <= pwdata[7:0];
			if (paddr == OFS_IEN && !lfc_q[7])
				ien_q <= pwdata[3:0];
			if (paddr == OFS_IMSK)
				msk_q <= pwdata[2:0];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_stray; pready |-> psel && penable && $past(psel && !penable); endproperty
	a_stray: assert property (p_stray) else $error("stray ready");
	property p_err; psel && !penable |=> pslverr == !$past(map); endproperty
	a_err: assert property (p_err) else $error("bad error response");
	property p_lfc; rd && paddr == OFS_LFC |-> prdata == {24'h0, lfc_q}; endproperty
	a_lfc: assert property (p_lfc) else $error("format readback wrong");
	property p_ofs1; rd && paddr == OFS_IEN |-> prdata == {24'h0, lfc_q[7] ? dhi_q : {4'h0, ien_q}}; endproperty
	a_ofs1: assert property (p_ofs1) else $error("offset one readback wrong");
	// Both samples set means the output register has seen the force
	property p_force; lfc_q[6] && $past(lfc_q[6]) |-> !serial_out; endproperty
	a_force: assert property (p_force) else $error("line not held low");
	property p_bit; $fell(serial_out) |-> !serial_out [*8]; endproperty
	a_bit: assert property (p_bit) else $error("low bit too short");
	property p_irq; msk_q == 3'h0 && $past(msk_q) == 3'h0 |-> !irq; endproperty
	a_irq: assert property (p_irq) else $error("irq while masked");
	c_err: cover property (pslverr);
	c_irq: cover property ($rose(irq));
	c_force: cover property (lfc_q[6] && !serial_out);
endmodule : ulf_uart_monitor

bind ulf_uart ulf_uart_monitor #(.DEPTH(DEPTH)) ulf_uart_monitor_inst (.pclk(pclk), .presetn(presetn),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in(serial_in), .serial_out(serial_out),
	.irq(irq));

// ### testbench/ulf_remote.sv
// Remote serial device model: sends frames to the core and decodes its output
`timescale 1ns/1ps
module ulf_remote #(
	parameter int BITC = 16
)(
	input wire logic pclk,
	input wire logic rx,
	input wire logic [3:0] nbits,
	input wire logic par_en,
	output logic tx
);
	logic [7:0] got;
	logic par;
	int cnt = 0;
	int per = 0;
	int cyc = 0;
	int last = 0;
	initial tx = 1'b1;
	// Free cycle count, used for start-to-start spacing
	always @(posedge pclk) cyc <= cyc + 1;
	// Decoder samples mid-bit, low bit first
	initial forever
	begin
		@(negedge rx);
		per = cyc - last;
		last = cyc;
		got = 8'h00;
		repeat (BITC / 2) @(posedge pclk);
		for (int i = 0; i < nbits; i++)
		begin
			repeat (BITC) @(posedge pclk);
			got[i] = rx;
		end
		if (par_en)
		begin
			repeat (BITC) @(posedge pclk);
			par = rx;
		end
		repeat (BITC) @(posedge pclk);
		cnt++;
	end
	// Sender drives one frame; line returns high after the stop
	task automatic send(input logic [7:0] d, input logic p);
		tx <= 1'b0;
		repeat (BITC) @(posedge pclk);
		for (int i = 0; i < nbits; i++)
		begin
			tx <= d[i];
			repeat (BITC) @(posedge pclk);
		end
		if (par_en)
		begin
			tx <= p;
			repeat (BITC) @(posedge pclk);
		end
		tx <= 1'b1;
		repeat (BITC) @(posedge pclk);
	endtask : send
endmodule : ulf_remote

// ### testbench/tb_top.sv
// Self-checking bench for the serial port core
`timescale 1ns/1ps
module tb_top
	import ulf_pkg::*;
;
	typedef struct packed {
		logic [7:0] lfc;
		logic [7:0] d;
		logic p;
		logic [15:0] len;
	} ulf_row_s;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serial_in, serial_out, irq, pe, re;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rq;
	logic [3:0] nb;
	int errors = 0;
	int n_checks = 0;
	int c0, k;
	// Format, data, parity bit and frame length in clocks at divisor one
	ulf_row_s rows [8] = '{{8'h00, 8'hA5, 1'b0, 16'h0070}, {8'h05, 8'h3C, 1'b0, 16'h0090},
		{8'h04, 8'h13, 1'b0, 16'h0078}, {8'h0B, 8'h5A, 1'b1, 16'h00B0}, {8'h1A, 8'h37, 1'b1, 16'h00A0},
		{8'h2B, 8'h81, 1'b1, 16'h00B0}, {8'h3F, 8'hFF, 1'b0, 16'h00C0}, {8'h1F, 8'h00, 1'b0, 16'h00C0}};
	ulf_uart ulf_uart_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_in(serial_in), .serial_out(serial_out), .irq(irq));
	ulf_remote ulf_remote_inst (.pclk(pclk), .rx(serial_out), .nbits(nb), .par_en(pe), .tx(serial_in));
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("Error at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	// One APB transfer; request held until ready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			errors++;
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic results;
		$display("Checks %0d, errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: runs well past the expected few thousand cycles
	initial
	begin
		repeat (20000) @(posedge pclk);
		errors++;
		results();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, nb, pe} = '0;
		nb = 4'h5;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		chk(serial_out, 1);
		apb(0, OFS_LFC, 0); // format cleared
		chk(rq, 0); // format cleared
		apb(0, 12'h010, 0);
		chk(re, 1);
		apb(1, OFS_LFC, 32'h83);
		apb(1, OFS_IEN, 32'h12);
		apb(0, OFS_IEN, 0); // divisor high byte
		chk(rq, 32'h12); // divisor high byte
		apb(1, OFS_IEN, 32'h00);
		apb(1, OFS_LFC, 32'h03);
		apb(1, OFS_IEN, 32'hFF);
		apb(0, OFS_IEN, 0);
		chk(rq, 32'h0F); // enable bits only
		apb(1, OFS_IEN, 32'h00);
		apb(1, OFS_LFC, 32'h43);
		repeat (20) @(posedge pclk);
		chk(serial_out, 0); // forced low
		apb(1, OFS_LFC, 32'h03);
		repeat (150) @(posedge pclk);
		$display("Register tests done");
		// Ordinary cases: two bytes back to back through the transmit queue
		apb(1, OFS_IID, 32'h01);
		foreach (rows[i])
		begin
			apb(1, OFS_LFC, {24'h0, rows[i].lfc});
			nb = 4'h5 + {2'b00, rows[i].lfc[1:0]};
			pe = rows[i].lfc[3];
			c0 = ulf_remote_inst.cnt;
			apb(1, OFS_DATA, {24'h0, rows[i].d}); // queued
			apb(1, OFS_DATA, {24'h0, rows[i].d});
			k = 0;
			while (ulf_remote_inst.cnt < c0 + 2 && k < 1000)
			begin
				@(posedge pclk);
				k++;
			end
			if (k >= 1000)
				errors++;
			chk(ulf_remote_inst.got, rows[i].d & (8'hFF >> (3 - rows[i].lfc[1:0]))); // length
			if (pe)
				chk(ulf_remote_inst.par, rows[i].p); // parity
			chk(ulf_remote_inst.per >= rows[i].len && ulf_remote_inst.per < rows[i].len + 8, 1); // stops
			repeat (40) @(posedge pclk);
		end
		$display("Transmit table done");
		// Receive path with interrupt, then a parity fault
		apb(1, OFS_IEN, 32'h01);
		apb(1, OFS_IMSK, 32'h01);
		apb(1, OFS_LFC, 32'h1B);
		nb = 4'h8;
		pe = 1'b1;
		ulf_remote_inst.send(8'hC6, 1'b0);
		repeat (40) @(posedge pclk);
		chk(irq, 1);
		apb(0, OFS_LSR, 0);
		chk(rq[2:0], 3'h1); // data ready, parity good
		apb(0, OFS_DATA, 0);
		chk(rq, 32'hC6); // received byte
		apb(0, OFS_LSR, 0);
		chk(rq[0], 0); // ready drops once empty
		apb(0, OFS_IST, 0);
		repeat (3) @(posedge pclk);
		chk(irq, 0);
		ulf_remote_inst.send(8'hC6, 1'b1);
		repeat (40) @(posedge pclk);
		apb(0, OFS_LSR, 0);
		chk(rq[2], 1); // wrong parity seen
		apb(0, OFS_LSR, 0);
		chk(rq[2], 0); // flag cleared by read
		$display("Receive tests done");
		results();
	end
endmodule : tb_top
